// ===== logic/monitor_i2c_slave_register_port.sv
// two-wire slave port and register file of the voltage/current/temperature monitor
module monitor_i2c_slave_register_port
  import mon_i2c_pkg::*;
(
  input  wire logic       core_clk_i,
  input  wire logic       resetn_i,
  input  wire logic       scl_i,
  input  wire logic       sda_i,
  output logic            sda_o,
  output logic            sda_oe_o,
  input  wire logic       addr_strap_low_i,
  input  wire logic       addr_strap_high_i,
  input  wire logic       result_wr_i,
  input  wire logic [2:0] result_sel_i,
  input  wire logic [6:0] result_msb_i,
  input  wire logic [7:0] result_lsb_i,
  input  wire logic       conv_done_i,
  output logic [7:0]      config_o,
  output logic            kelvin_o,
  output logic            single_o,
  output logic            trigger_o,
  output logic            busy_o
);
  import mon_i2c_pkg::*;

  i2c_evt_if evt ();

  i2c_pin_front u_front (
    .core_clk_i   (core_clk_i),
    .resetn_i     (resetn_i),
    .scl_i        (scl_i),
    .sda_i        (sda_i),
    .strap_low_i  (addr_strap_low_i),
    .strap_high_i (addr_strap_high_i),
    .evt          (evt)
  );

  port_state_t state, next_state;
  logic [3:0]  bitcnt, next_bitcnt;
  logic [7:0]  shreg, next_shreg;
  logic [3:0]  ptr, next_ptr;
  logic        rw, next_rw;
  logic        mack, next_mack;
  logic        oe, next_oe;
  logic [7:0]  cfg, next_cfg;
  logic        next_trig;
  logic        busy, next_busy;
  logic [5:0]  ready, next_ready;
  logic [7:0]  res_mem [NUM_RES_BYTES];
  logic [7:0]  next_res_mem [NUM_RES_BYTES];
  logic [7:0]  tx_byte;
  logic [5:0]  rd_clear;

  // result register pointed at, as a ready-flag index
  function automatic logic [2:0] res_index(input logic [3:0] p);
    logic [3:0] off;
    off = p - REG_RESULT_BASE;
    return off[3:1];
  endfunction

  function automatic logic is_result(input logic [3:0] p);
    return p >= REG_RESULT_BASE;
  endfunction

  function automatic logic [7:0] read_byte(input logic [3:0] p);
    logic [7:0] b;
    b = REG_RESET;
    if (p == REG_STATUS || p == REG_TRIGGER) begin
      b = {1'b0, ready, busy};
    end else if (p == REG_CONFIG) begin
      b = cfg;
    end else if (is_result(p)) begin
      b = res_mem[4'(p - REG_RESULT_BASE)];
      if (!p[0]) begin
        b[7] = ready[res_index(p)];
      end
    end
    return b;
  endfunction

  always_comb begin
    next_state   = state;
    next_bitcnt  = bitcnt;
    next_shreg   = shreg;
    next_ptr     = ptr;
    next_rw      = rw;
    next_mack    = mack;
    next_oe      = oe;
    next_cfg     = cfg;
    next_trig    = 1'b0;
    next_busy    = busy;
    rd_clear     = 6'h00;
    tx_byte      = read_byte(ptr);
    next_res_mem = res_mem;

    if (evt.scl_rise) begin
      if (state == ST_ADDR || state == ST_CMD || state == ST_WDATA) begin
        next_shreg  = {shreg[6:0], evt.sda};
        next_bitcnt = bitcnt + 4'h1;
      end
      if (state == ST_RDATA && bitcnt == BYTE_BITS + 4'h1) begin
        next_mack = ~evt.sda;
      end
    end

    if (evt.scl_fall) begin
      case (state)
        ST_ADDR: begin
          if (bitcnt == BYTE_BITS) begin
            if ((shreg[7:1] == {ADDR_PREFIX, evt.strap}) || (shreg == SYNC_ADDR)) begin
              next_oe    = 1'b0;
              next_rw    = shreg[0];
              next_state = ST_AACK;
            end else begin
              next_state = ST_IDLE;
            end
          end
        end
        ST_AACK, ST_RDATA: begin
          if (state == ST_RDATA && bitcnt == BYTE_BITS) begin
            next_oe     = 1'b1;
            next_bitcnt = bitcnt + 4'h1;
          end else if (state == ST_RDATA && bitcnt < BYTE_BITS) begin
            next_shreg  = {shreg[6:0], 1'b0};
            next_oe     = shreg[6];
            next_bitcnt = bitcnt + 4'h1;
          end else if ((state == ST_AACK && rw) || (state == ST_RDATA && mack)) begin
            next_shreg  = tx_byte;
            next_oe     = tx_byte[7];
            next_bitcnt = 4'h1;
            next_ptr    = ptr + 4'h1;
            next_mack   = 1'b0;
            next_state  = ST_RDATA;
            if (is_result(ptr)) begin
              rd_clear[res_index(ptr)] = 1'b1;
            end
          end else if (state == ST_AACK) begin
            next_oe     = 1'b1;
            next_bitcnt = 4'h0;
            next_state  = ST_CMD;
          end else begin
            next_oe    = 1'b1;
            next_state = ST_IDLE;
          end
        end
        ST_CMD: begin
          if (bitcnt == BYTE_BITS) begin
            next_ptr   = shreg[3:0];
            next_oe    = 1'b0;
            next_state = ST_CACK;
          end
        end
        ST_WDATA: begin
          if (bitcnt == BYTE_BITS) begin
            if (ptr == REG_CONFIG) begin
              next_cfg = shreg;
            end
            if (ptr == REG_TRIGGER) begin
              next_trig = 1'b1;
            end
            next_ptr   = ptr + 4'h1;
            next_oe    = 1'b0;
            next_state = ST_WACK;
          end
        end
        ST_CACK, ST_WACK: begin
          next_oe     = 1'b1;
          next_bitcnt = 4'h0;
          next_state  = ST_WDATA;
        end
        ST_IDLE: begin
          next_oe = 1'b1;
        end
        default: begin
          next_oe    = 1'b1;
          next_state = ST_IDLE;
        end
      endcase
    end

    if (evt.start) begin
      next_state  = ST_ADDR;
      next_bitcnt = 4'h0;
      next_oe     = 1'b1;
    end else if (evt.stop) begin
      next_state = ST_IDLE;
      next_oe    = 1'b1;
    end

    // a fresh result beats a simultaneous read clear
    next_ready = ready & ~rd_clear;
    if (result_wr_i && 32'(result_sel_i) < NUM_RESULTS) begin
      next_ready[result_sel_i]            = 1'b1;
      next_res_mem[{result_sel_i, 1'b0}]  = {1'b0, result_msb_i};
      next_res_mem[{result_sel_i, 1'b1}]  = result_lsb_i;
    end

    if (next_trig) begin
      next_busy = 1'b1;
    end else if (conv_done_i && cfg[CFG_SINGLE_BIT]) begin
      next_busy = 1'b0;
    end
  end

  always_ff @(posedge core_clk_i) begin
    if (!resetn_i) begin
      state    <= ST_IDLE;
      bitcnt   <= 4'h0;
      shreg    <= REG_RESET;
      ptr      <= REG_STATUS;
      rw       <= 1'b0;
      mack     <= 1'b0;
      oe       <= 1'b1;
      cfg      <= REG_RESET;
      busy     <= 1'b0;
      ready    <= 6'h00;
      sda_o    <= 1'b0;
      sda_oe_o <= 1'b1;
      config_o <= REG_RESET;
      kelvin_o <= 1'b0;
      single_o <= 1'b0;
      trigger_o <= 1'b0;
      busy_o   <= 1'b0;
      for (int i = 0; i < NUM_RES_BYTES; i++) begin
        res_mem[i] <= REG_RESET;
      end
    end else begin
      state    <= next_state;
      bitcnt   <= next_bitcnt;
      shreg    <= next_shreg;
      ptr      <= next_ptr;
      rw       <= next_rw;
      mack     <= next_mack;
      oe       <= next_oe;
      cfg      <= next_cfg;
      busy     <= next_busy;
      ready    <= next_ready;
      sda_o    <= 1'b0;
      sda_oe_o <= next_oe;
      config_o <= next_cfg;
      kelvin_o <= next_cfg[CFG_SCALE_BIT];
      single_o <= next_cfg[CFG_SINGLE_BIT];
      trigger_o <= next_trig;
      busy_o   <= next_busy;
      for (int i = 0; i < NUM_RES_BYTES; i++) begin
        res_mem[i] <= next_res_mem[i];
      end
    end
  end
endmodule

// ===== logic/mon_i2c_pkg.sv
// constants shared by the monitor two-wire slave port
package mon_i2c_pkg;
  localparam logic [3:0] REG_STATUS      = 4'h0;
  localparam logic [3:0] REG_CONFIG      = 4'h1;
  localparam logic [3:0] REG_TRIGGER     = 4'h2;
  localparam logic [3:0] REG_UNUSED      = 4'h3;
  localparam logic [3:0] REG_RESULT_BASE = 4'h4;
  localparam logic [4:0] ADDR_PREFIX     = 5'h13;
  localparam logic [7:0] SYNC_ADDR       = 8'hee;
  localparam logic [7:0] REG_RESET       = 8'h00;
  localparam int         CFG_SCALE_BIT   = 7;
  localparam int         CFG_SINGLE_BIT  = 6;
  localparam int         NUM_RESULTS     = 6;
  localparam int         NUM_RES_BYTES   = 12;
  localparam logic [3:0] BYTE_BITS       = 4'h8;

  typedef enum logic [7:0] {
    ST_IDLE  = 8'h01,
    ST_ADDR  = 8'h02,
    ST_AACK  = 8'h04,
    ST_CMD   = 8'h08,
    ST_CACK  = 8'h10,
    ST_WDATA = 8'h20,
    ST_WACK  = 8'h40,
    ST_RDATA = 8'h80
  } port_state_t;
endpackage

// ===== logic/i2c_evt_if.sv
// line events passed from the pin front end to the slave core
interface i2c_evt_if;
  logic       scl_rise;
  logic       scl_fall;
  logic       start;
  logic       stop;
  logic       sda;
  logic [1:0] strap;
  modport front (output scl_rise, scl_fall, start, stop, sda, strap);
  modport core  (input  scl_rise, scl_fall, start, stop, sda, strap);
endinterface

// ===== logic/i2c_pin_front.sv
// synchronises the bus and strap pins and finds clock edges, start and stop
module i2c_pin_front (
  input  wire logic core_clk_i,
  input  wire logic resetn_i,
  input  wire logic scl_i,
  input  wire logic sda_i,
  input  wire logic strap_low_i,
  input  wire logic strap_high_i,
  i2c_evt_if.front  evt
);
  logic [3:0] sync1, sync2, next_sync1, next_sync2;
  logic       scl_d, sda_d, next_scl_d, next_sda_d;

  always_comb begin
    next_sync1 = {strap_high_i, strap_low_i, sda_i, scl_i};
    next_sync2 = sync1;
    next_scl_d = sync2[0];
    next_sda_d = sync2[1];
  end

  // idle lines rest high, so reset to high
  always_ff @(posedge core_clk_i) begin
    if (!resetn_i) begin
      sync1 <= 4'h3;
      sync2 <= 4'h3;
      scl_d <= 1'b1;
      sda_d <= 1'b1;
    end else begin
      sync1 <= next_sync1;
      sync2 <= next_sync2;
      scl_d <= next_scl_d;
      sda_d <= next_sda_d;
    end
  end

  assign evt.scl_rise = sync2[0] & ~scl_d;
  assign evt.scl_fall = ~sync2[0] & scl_d;
  assign evt.start    = sync2[0] & scl_d & sda_d & ~sync2[1];
  assign evt.stop     = sync2[0] & scl_d & ~sda_d & sync2[1];
  assign evt.sda      = sync2[1];
  assign evt.strap    = sync2[3:2];
endmodule

// ===== testbench/mon_port_props.sv
// assertions on the monitor slave port pins
module mon_port_props
  import mon_i2c_pkg::*;
(
  input wire logic       core_clk_i,
  input wire logic       resetn_i,
  input wire logic       sda_o,
  input wire logic       sda_oe_o,
  input wire logic       conv_done_i,
  input wire logic [7:0] config_o,
  input wire logic       kelvin_o,
  input wire logic       single_o,
  input wire logic       trigger_o,
  input wire logic       busy_o
);
  timeunit 1ns;
  timeprecision 1ps;
  default clocking cb @(posedge core_clk_i);
  endclocking
  default disable iff (!resetn_i);
  sequence s_pulse;
    trigger_o ##1 !trigger_o;
  endsequence
  // a pulled-low level lasts most of one bus clock period
  sequence s_hold;
    (!sda_oe_o && !sda_o) [*6];
  endsequence
  property p_rst;
    disable iff (1'b0) !resetn_i |=> sda_oe_o && config_o == REG_RESET && !busy_o && !trigger_o;
  endproperty
  property p_scale;
    kelvin_o == config_o[CFG_SCALE_BIT];
  endproperty
  property p_single;
    single_o == config_o[CFG_SINGLE_BIT];
  endproperty
  property p_trig;
    trigger_o |-> s_pulse;
  endproperty
  property p_bset;
    trigger_o |-> ##[0:2] busy_o;
  endproperty
  property p_bhold;
    busy_o && !single_o |=> busy_o;
  endproperty
  property p_bclr;
    conv_done_i && single_o |=> !busy_o || trigger_o;
  endproperty
  property p_drv;
    $fell(sda_oe_o) |=> s_hold;
  endproperty
  a_rst: assert property (p_rst) else $error("reset state wrong");
  a_scale: assert property (p_scale) else $error("scale output wrong");
  a_single: assert property (p_single) else $error("single output wrong");
  a_trig: assert property (p_trig) else $error("trigger not a pulse");
  a_bset: assert property (p_bset) else $error("busy not set");
  a_bhold: assert property (p_bhold) else $error("busy dropped in repeat");
  a_bclr: assert property (p_bclr) else $error("busy not cleared");
  a_drv: assert property (p_drv) else $error("data line low level too short");
endmodule

bind monitor_i2c_slave_register_port mon_port_props u_props (.core_clk_i, .resetn_i, .sda_o, .sda_oe_o,
  .conv_done_i, .config_o, .kelvin_o, .single_o, .trigger_o, .busy_o);

// ===== testbench/i2c_master_model.sv
// bus master model for the two-wire port, open-drain data
module i2c_master_model (
  input  wire logic core_clk_i,
  input  wire logic sda_line_i,
  output logic      scl_o,
  output logic      sda_rel_o
);
  timeunit 1ns;
  timeprecision 1ps;
  initial begin
    scl_o = 1'b1;
    sda_rel_o = 1'b1;
  end
  task automatic tk(input int n);
    repeat (n) @(posedge core_clk_i);
  endtask
  task automatic bit_io(input logic b, output logic r);
    tk(1);
    sda_rel_o <= b;
    tk(3);
    scl_o <= 1'b1;
    tk(2);
    r = sda_line_i;
    tk(2);
    scl_o <= 1'b0;
  endtask
  task automatic start();
    tk(1);
    sda_rel_o <= 1'b1;
    tk(5);
    scl_o <= 1'b1;
    tk(4);
    sda_rel_o <= 1'b0;
    tk(4);
    scl_o <= 1'b0;
  endtask
  task automatic stop();
    tk(1);
    sda_rel_o <= 1'b0;
    tk(3);
    scl_o <= 1'b1;
    tk(4);
    sda_rel_o <= 1'b1;
    tk(4);
  endtask
  task automatic put(input logic [7:0] d, output logic ack);
    for (int i = 7; i >= 0; i--) bit_io(d[i], ack);
    bit_io(1'b1, ack);
  endtask
  task automatic get(input logic nack, output logic [7:0] d);
    logic r;
    for (int i = 7; i >= 0; i--) begin
      bit_io(1'b1, r);
      d[i] = r;
    end
    bit_io(nack, r);
  endtask
endmodule

// ===== testbench/test_monitor_i2c_slave_register_port.sv
// self-checking bench of the monitor slave port
`define CHK(n, e, g) begin n_tests++; if ((g) !== (e)) begin fail_count++; $display("unexpected %s exp %h got %h", n, e, g); end end
module test_monitor_i2c_slave_register_port;
  timeunit 1ns;
  timeprecision 1ps;
  import mon_i2c_pkg::*;
  localparam logic [7:0] ADR = {ADDR_PREFIX, 2'b10, 1'b0};
  logic       core_clk_i   = 1'b0;
  logic       resetn_i     = 1'b0;
  logic       result_wr_i  = 1'b0;
  logic [2:0] result_sel_i = 3'h0;
  logic [6:0] result_msb_i = 7'h00;
  logic [7:0] result_lsb_i = 8'h00;
  logic       conv_done_i  = 1'b0;
  logic       addr_strap_low_i  = 1'b0;
  logic       addr_strap_high_i = 1'b1;
  logic       scl, rel, sda_o, sda_oe_o, kelvin_o, single_o, trigger_o, busy_o;
  logic [7:0] config_o;
  wire logic  line = rel & (sda_oe_o | sda_o);
  int         fail_count = 0;
  int         n_tests = 0;
  int         trg_n = 0;
  int         cyc = 0;
  i2c_master_model m (.core_clk_i, .sda_line_i(line), .scl_o(scl), .sda_rel_o(rel));
  monitor_i2c_slave_register_port dut (.core_clk_i, .resetn_i, .scl_i(scl), .sda_i(line), .sda_o, .sda_oe_o,
    .addr_strap_low_i, .addr_strap_high_i, .result_wr_i, .result_sel_i, .result_msb_i,
    .result_lsb_i, .conv_done_i, .config_o, .kelvin_o, .single_o, .trigger_o, .busy_o);
  initial forever #20 core_clk_i = ~core_clk_i;
  always @(posedge core_clk_i) begin
    cyc++;
    if (trigger_o === 1'b1) trg_n++;
    if (cyc == 20000) begin
      fail_count++;
      complete_run();
    end
  end
  task automatic complete_run();
    $display("comparisons %0d mismatches %0d", n_tests, fail_count);
    if (fail_count == 0 && n_tests > 0) $display("verification passed");
    else $display("verification failed");
    $finish;
  endtask
  task automatic wr(input logic [7:0] a, input logic [7:0] b [3], input int n, input logic ea);
    logic k;
    m.start();
    m.put(a, k);
    `CHK("addr ack", ea, k)
    for (int i = 0; i < n; i++) begin
      m.put(b[i], k);
      `CHK("data ack", 1'b0, k)
    end
    m.stop();
  endtask
  task automatic rd(input logic [7:0] c, input logic [7:0] e [3], input int n);
    logic k;
    logic [7:0] d;
    m.start();
    m.put(ADR, k);
    m.put(c, k);
    m.start();
    m.put(ADR | 8'h01, k);
    `CHK("read ack", 1'b0, k)
    for (int i = 0; i < n; i++) begin
      m.get(i == n - 1, d);
      `CHK("read byte", e[i], d)
    end
    m.stop();
  endtask
  task automatic done_pulse();
    conv_done_i <= 1'b1;
    @(posedge core_clk_i);
    conv_done_i <= 1'b0;
    repeat (3) @(posedge core_clk_i);
  endtask
  task automatic test_reset();
    repeat (2) @(posedge core_clk_i);
    resetn_i <= 1'b1;
    repeat (6) @(posedge core_clk_i);
    `CHK("config", REG_RESET, config_o)
    `CHK("busy", 1'b0, busy_o)
    `CHK("release", 1'b1, sda_oe_o)
    $display("test reset done");
  endtask
  task automatic test_refuse();
    wr(8'h98, '{8'h00, 8'h00, 8'h00}, 0, 1'b1);
    wr(SYNC_ADDR | 8'h01, '{8'h00, 8'h00, 8'h00}, 0, 1'b1);
    // other strap levels move the answered address
    addr_strap_low_i  <= 1'b1;
    addr_strap_high_i <= 1'b0;
    wr(8'h9a, '{8'h00, 8'h00, 8'h00}, 0, 1'b0);
    wr(ADR, '{8'h00, 8'h00, 8'h00}, 0, 1'b1);
    addr_strap_low_i  <= 1'b0;
    addr_strap_high_i <= 1'b1;
    $display("test refuse done");
  endtask
  task automatic test_write();
    wr(ADR, '{8'hf1, 8'hc0, 8'h00}, 3, 1'b0);
    `CHK("config", 8'hc0, config_o)
    `CHK("kelvin", 1'b1, kelvin_o)
    `CHK("single", 1'b1, single_o)
    `CHK("trigger", 1, trg_n)
    `CHK("busy", 1'b1, busy_o)
    done_pulse();
    `CHK("busy", 1'b0, busy_o)
    wr(SYNC_ADDR, '{8'h02, 8'h55, 8'h00}, 2, 1'b0);
    `CHK("trigger", 2, trg_n)
    $display("test write done");
  endtask
  task automatic test_read();
    done_pulse();
    result_sel_i <= 3'h5;
    result_msb_i <= 7'h2a;
    result_lsb_i <= 8'h5c;
    result_wr_i <= 1'b1;
    @(posedge core_clk_i);
    result_wr_i <= 1'b0;
    rd(8'h02, '{8'h40, 8'h00, 8'h00}, 1);
    rd(8'h0e, '{8'haa, 8'h5c, 8'h00}, 3);
    $display("test read done");
  endtask
  task automatic test_repeat();
    wr(ADR, '{8'h01, 8'h00, 8'h00}, 3, 1'b0);
    done_pulse();
    `CHK("kelvin", 1'b0, kelvin_o)
    `CHK("single", 1'b0, single_o)
    `CHK("busy", 1'b1, busy_o)
    $display("test repeat done");
  endtask
  initial begin
    test_reset();
    test_refuse();
    test_write();
    test_read();
    test_repeat();
    complete_run();
  end
endmodule
